// *** rtl/tcc_cc_control_regs.sv ***
// Type-C CC control register bank with decoded controls for the detection FSM
//
// What this block does
// - Force bit at zero holds VCONN off; at one VCONN follows the FSM.
// - Try.SNK entry allowed only while the Try.SNK permit bit is one.
// - Debug accessory source-mode detection enabled only while its bit is set.
// - Debug accessory sink-mode detection enabled only while its bit is set.
// - Audio adapter detection enabled only while its enable bit is set.
// - Source detection follows source enable bit; sink detection follows sink bit.
// - Advertised-current field captured when software writes one to change request, unless it holds reserved code 3, which clears the request.
// - Captured current change applies only while the state code reads 010.
// - Low-power field picks 80, 5 or 1 microamp source in Unattached.SRC.
// - Forced-current code zero leaves current source choice to the FSM.
// - Codes one to five force 1/5/80/180/330 microamps; other codes force none.
// - Detection FSM runs only while the detection enable bit is one.
// - TryWait.SRC to Attached.SRC debounce is 120 ms, or 15 ms when short.
// - Error-lock bit at one keeps the FSM in ErrorRecovery.
// - With both roles enabled, duty field sets Unattached.SRC share 35 to 50 percent.
// - VBUS-ignore bit at one skips VBUS check on sink attach.
// - Sink exit select adds CC below Ra/Rd threshold as exit cause.
// - Ladder disable bit high disconnects the CC resistor ladder.
// - Quick second debounce is 1, 2, 3 or 20 ms by two-bit field.
// - Change request bit clears itself once the pull-up change is applied.
`timescale 1ns/1ps

module tcc_cc_control_regs #(
    parameter int TRYWAIT_LONG_CYC = tcc_pkg::TRYWAIT_LONG_CYC,
    parameter int TRYWAIT_SHORT_CYC = tcc_pkg::TRYWAIT_SHORT_CYC,
    parameter int QDEB_0_CYC = tcc_pkg::QDEB_0_CYC,
    parameter int QDEB_1_CYC = tcc_pkg::QDEB_1_CYC,
    parameter int QDEB_2_CYC = tcc_pkg::QDEB_2_CYC,
    parameter int QDEB_3_CYC = tcc_pkg::QDEB_3_CYC
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic [2:0] attach_state_code,
    input wire logic fsm_vconn_request,
    output tcc_pkg::tcc_cfg_t cfg
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [7:0] mode_enables_reg;
    logic [7:0] current_select_reg;
    logic [7:0] fsm_enable_reg;
    logic [7:0] timing_lock_reg;
    logic [7:0] sink_conditions_reg;
    logic [7:0] ladder_debounce_reg;
    logic change_req_reg;
    logic change_req_next;
    logic [1:0] pending_current_reg;
    logic [1:0] pending_current_next;
    logic [1:0] applied_current_reg;
    logic [1:0] applied_current_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic rvalid_reg;
    tcc_pkg::tcc_cfg_t cfg_reg;
    tcc_pkg::tcc_cfg_t cfg_next;

    logic wr_change;
    logic wr_mode;
    logic wr_current;
    logic wr_fsm;
    logic wr_timing;
    logic wr_sink;
    logic wr_ladder;
    logic [1:0] req_field;
    logic capture;
    logic apply;

    assign wr_change = reg_wr && (reg_addr == tcc_pkg::OFF_CHANGE_REQ);
    assign wr_mode = reg_wr && (reg_addr == tcc_pkg::OFF_MODE_ENABLES);
    assign wr_current = reg_wr && (reg_addr == tcc_pkg::OFF_CURRENT_SELECT);
    assign wr_fsm = reg_wr && (reg_addr == tcc_pkg::OFF_FSM_ENABLE);
    assign wr_timing = reg_wr && (reg_addr == tcc_pkg::OFF_TIMING_LOCK);
    assign wr_sink = reg_wr && (reg_addr == tcc_pkg::OFF_SINK_CONDITIONS);
    assign wr_ladder = reg_wr && (reg_addr == tcc_pkg::OFF_LADDER_DEBOUNCE);

    // Field as it stands when the request is written, not a later rewrite
    assign req_field = current_select_reg[tcc_pkg::POS_ADV_CURRENT +: 2];
    assign capture = wr_change && reg_wdata[tcc_pkg::BIT_CHANGE_REQ];
    assign apply = change_req_reg && (attach_state_code == tcc_pkg::STATE_DFP);

    // ------------------------------------------------------------
    // Plain configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_enables_reg <= tcc_pkg::RST_MODE_ENABLES;
            current_select_reg <= tcc_pkg::RST_CURRENT_SELECT;
            fsm_enable_reg <= tcc_pkg::RST_FSM_ENABLE;
            timing_lock_reg <= tcc_pkg::RST_TIMING_LOCK;
            sink_conditions_reg <= tcc_pkg::RST_SINK_CONDITIONS;
            ladder_debounce_reg <= tcc_pkg::RST_LADDER_DEBOUNCE;
        end else begin
            if (wr_mode) begin
                mode_enables_reg <= reg_wdata & tcc_pkg::MASK_MODE_ENABLES;
            end
            if (wr_current) begin
                current_select_reg <= reg_wdata & tcc_pkg::MASK_CURRENT_SELECT;
            end
            if (wr_fsm) begin
                fsm_enable_reg <= reg_wdata & tcc_pkg::MASK_FSM_ENABLE;
            end
            if (wr_timing) begin
                timing_lock_reg <= reg_wdata & tcc_pkg::MASK_TIMING_LOCK;
            end
            if (wr_sink) begin
                sink_conditions_reg <= reg_wdata & tcc_pkg::MASK_SINK_CONDITIONS;
            end
            if (wr_ladder) begin
                ladder_debounce_reg <= reg_wdata & tcc_pkg::MASK_LADDER_DEBOUNCE;
            end
        end
    end

    // ------------------------------------------------------------
    // Advertised-current change request
    // ------------------------------------------------------------
    // A fresh request in the apply cycle wins over the self-clear
    always_comb begin
        change_req_next = change_req_reg;
        pending_current_next = pending_current_reg;
        applied_current_next = applied_current_reg;
        if (apply) begin
            applied_current_next = pending_current_reg;
            change_req_next = 1'b0;
        end
        if (capture) begin
            if (req_field == tcc_pkg::ADV_RESERVED) begin
                change_req_next = 1'b0;
            end else begin
                pending_current_next = req_field;
                change_req_next = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            change_req_reg <= 1'b0;
            pending_current_reg <= 2'h0;
            applied_current_reg <= 2'h0;
        end else begin
            change_req_reg <= change_req_next;
            pending_current_reg <= pending_current_next;
            applied_current_reg <= applied_current_next;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_comb begin
        rdata_next = 8'h00;
        unique case (reg_addr)
            tcc_pkg::OFF_CHANGE_REQ: begin
                rdata_next[tcc_pkg::BIT_CHANGE_REQ] = change_req_reg;
            end
            tcc_pkg::OFF_MODE_ENABLES: begin
                rdata_next = mode_enables_reg;
            end
            tcc_pkg::OFF_CURRENT_SELECT: begin
                rdata_next = current_select_reg;
            end
            tcc_pkg::OFF_FSM_ENABLE: begin
                rdata_next = fsm_enable_reg;
            end
            tcc_pkg::OFF_TIMING_LOCK: begin
                rdata_next = timing_lock_reg;
            end
            tcc_pkg::OFF_SINK_CONDITIONS: begin
                rdata_next = sink_conditions_reg;
            end
            tcc_pkg::OFF_LADDER_DEBOUNCE: begin
                rdata_next = ladder_debounce_reg;
            end
            default: begin
                rdata_next = 8'h00;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_reg <= 8'h00;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= reg_rd;
            if (reg_rd) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    assign reg_rdata = rdata_reg;
    assign reg_rvalid = rvalid_reg;

    // ------------------------------------------------------------
    // Decoded controls toward the detection FSM
    // ------------------------------------------------------------
    always_comb begin
        cfg_next = '0;
        cfg_next.fsm_run = fsm_enable_reg[tcc_pkg::BIT_FSM_RUN];
        // VCONN gated even if the FSM asks, so software can kill it
        cfg_next.vconn_on = mode_enables_reg[tcc_pkg::BIT_VCONN_AUTO]
            && fsm_vconn_request;
        cfg_next.try_sink_permit = mode_enables_reg[tcc_pkg::BIT_TRY_SINK];
        cfg_next.dbg_acc_source_detect_en = mode_enables_reg[tcc_pkg::BIT_DBG_SRC];
        cfg_next.dbg_acc_sink_detect_en = mode_enables_reg[tcc_pkg::BIT_DBG_SNK];
        cfg_next.audio_acc_detect_en = mode_enables_reg[tcc_pkg::BIT_AUDIO];
        cfg_next.source_role_detect_en = mode_enables_reg[tcc_pkg::BIT_SRC_EN];
        cfg_next.sink_role_detect_en = mode_enables_reg[tcc_pkg::BIT_SNK_EN];
        cfg_next.error_recovery_hold = timing_lock_reg[tcc_pkg::BIT_ERR_HOLD];
        cfg_next.vbus_ignore_on_attach =
            sink_conditions_reg[tcc_pkg::BIT_VBUS_IGNORE];
        cfg_next.sink_exit_select = sink_conditions_reg[tcc_pkg::BIT_SINK_EXIT];
        cfg_next.resistor_ladder_off =
            ladder_debounce_reg[tcc_pkg::BIT_LADDER_OFF];
        cfg_next.adv_current_applied = applied_current_reg;

        // Duty only meaningful when toggling between both roles
        cfg_next.drp_toggle = mode_enables_reg[tcc_pkg::BIT_SRC_EN]
            && mode_enables_reg[tcc_pkg::BIT_SNK_EN];
        if (cfg_next.drp_toggle) begin
            unique case (timing_lock_reg[tcc_pkg::POS_DUAL_DUTY +: 2])
                2'h0: cfg_next.dual_role_duty_pct = tcc_pkg::DUTY_35;
                2'h1: cfg_next.dual_role_duty_pct = tcc_pkg::DUTY_40;
                2'h2: cfg_next.dual_role_duty_pct = tcc_pkg::DUTY_45;
                2'h3: cfg_next.dual_role_duty_pct = tcc_pkg::DUTY_50;
            endcase
        end

        unique case (current_select_reg[tcc_pkg::POS_LOWPOWER +: 2])
            tcc_pkg::LP_5UA: cfg_next.unattached_src_ua = tcc_pkg::UA_5;
            tcc_pkg::LP_1UA: cfg_next.unattached_src_ua = tcc_pkg::UA_1;
            default: cfg_next.unattached_src_ua = tcc_pkg::UA_80;
        endcase

        cfg_next.forced_active =
            current_select_reg[tcc_pkg::POS_FORCED +: 3] != tcc_pkg::FORCED_AUTO;
        unique case (current_select_reg[tcc_pkg::POS_FORCED +: 3])
            3'h0: cfg_next.forced_ua = 9'h000;
            3'h1: cfg_next.forced_ua = tcc_pkg::UA_1;
            3'h2: cfg_next.forced_ua = tcc_pkg::UA_5;
            3'h3: cfg_next.forced_ua = tcc_pkg::UA_80;
            3'h4: cfg_next.forced_ua = tcc_pkg::UA_180;
            3'h5: cfg_next.forced_ua = tcc_pkg::UA_330;
            default: begin
                cfg_next.forced_ua = 9'h000;
                cfg_next.forced_no_source = 1'b1;
            end
        endcase

        if (timing_lock_reg[tcc_pkg::BIT_TRYWAIT_SHORT]) begin
            cfg_next.trywait_debounce_cyc = TRYWAIT_SHORT_CYC[31:0];
        end else begin
            cfg_next.trywait_debounce_cyc = TRYWAIT_LONG_CYC[31:0];
        end

        unique case (ladder_debounce_reg[tcc_pkg::POS_QUICK_DEB +: 2])
            2'h0: cfg_next.quick_debounce_two_cyc = QDEB_0_CYC[31:0];
            2'h1: cfg_next.quick_debounce_two_cyc = QDEB_1_CYC[31:0];
            2'h2: cfg_next.quick_debounce_two_cyc = QDEB_2_CYC[31:0];
            2'h3: cfg_next.quick_debounce_two_cyc = QDEB_3_CYC[31:0];
        endcase
    end

    // Registered so the FSM sees glitch-free controls; costs one cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_reg <= '0;
        end else begin
            cfg_reg <= cfg_next;
        end
    end

    assign cfg = cfg_reg;

endmodule

// *** rtl/tcc_pkg.sv ***
// Package for the Type-C CC control register bank: map, fields, resets, timing
package tcc_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CHANGE_REQ = 8'h20;
    localparam logic [7:0] OFF_MODE_ENABLES = 8'h21;
    localparam logic [7:0] OFF_CURRENT_SELECT = 8'h22;
    localparam logic [7:0] OFF_FSM_ENABLE = 8'h23;
    localparam logic [7:0] OFF_TIMING_LOCK = 8'h24;
    localparam logic [7:0] OFF_SINK_CONDITIONS = 8'h25;
    localparam logic [7:0] OFF_LADDER_DEBOUNCE = 8'h26;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_MODE_ENABLES = 8'h8D;
    localparam logic [7:0] RST_CURRENT_SELECT = 8'h00;
    localparam logic [7:0] RST_FSM_ENABLE = 8'h01;
    localparam logic [7:0] RST_TIMING_LOCK = 8'h00;
    localparam logic [7:0] RST_SINK_CONDITIONS = 8'h03;
    localparam logic [7:0] RST_LADDER_DEBOUNCE = 8'h00;

    // ------------------------------------------------------------
    // Field positions and masks
    // ------------------------------------------------------------
    localparam int BIT_CHANGE_REQ = 5;
    localparam int BIT_VCONN_AUTO = 7;
    localparam int BIT_TRY_SINK = 6;
    localparam int BIT_DBG_SRC = 4;
    localparam int BIT_DBG_SNK = 3;
    localparam int BIT_AUDIO = 2;
    localparam int BIT_SRC_EN = 1;
    localparam int BIT_SNK_EN = 0;
    localparam int POS_ADV_CURRENT = 5;
    localparam int POS_LOWPOWER = 3;
    localparam int POS_FORCED = 0;
    localparam int BIT_FSM_RUN = 0;
    localparam int BIT_TRYWAIT_SHORT = 5;
    localparam int BIT_ERR_HOLD = 4;
    localparam int POS_DUAL_DUTY = 0;
    localparam int BIT_VBUS_IGNORE = 1;
    localparam int BIT_SINK_EXIT = 0;
    localparam int BIT_LADDER_OFF = 6;
    localparam int POS_QUICK_DEB = 0;
    localparam logic [7:0] MASK_MODE_ENABLES = 8'hDF;
    localparam logic [7:0] MASK_CURRENT_SELECT = 8'h7F;
    localparam logic [7:0] MASK_FSM_ENABLE = 8'h31;
    localparam logic [7:0] MASK_TIMING_LOCK = 8'h33;
    localparam logic [7:0] MASK_SINK_CONDITIONS = 8'h03;
    localparam logic [7:0] MASK_LADDER_DEBOUNCE = 8'h43;

    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    localparam logic [1:0] ADV_RESERVED = 2'h3;
    localparam logic [2:0] STATE_DFP = 3'h2;
    localparam logic [2:0] FORCED_AUTO = 3'h0;
    localparam logic [1:0] LP_NORMAL = 2'h0;
    localparam logic [1:0] LP_5UA = 2'h1;
    localparam logic [1:0] LP_1UA = 2'h2;
    localparam logic [8:0] UA_1 = 9'h001;
    localparam logic [8:0] UA_5 = 9'h005;
    localparam logic [8:0] UA_80 = 9'h050;
    localparam logic [8:0] UA_180 = 9'h0B4;
    localparam logic [8:0] UA_330 = 9'h14A;
    localparam logic [6:0] DUTY_35 = 7'h23;
    localparam logic [6:0] DUTY_40 = 7'h28;
    localparam logic [6:0] DUTY_45 = 7'h2D;
    localparam logic [6:0] DUTY_50 = 7'h32;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_KHZ = 250000;
    localparam int TRYWAIT_LONG_MS = 120;
    localparam int TRYWAIT_SHORT_MS = 15;
    localparam int QDEB_0_MS = 1;
    localparam int QDEB_1_MS = 2;
    localparam int QDEB_2_MS = 3;
    localparam int QDEB_3_MS = 20;
    localparam int TRYWAIT_LONG_CYC = TRYWAIT_LONG_MS * CLK_KHZ;
    localparam int TRYWAIT_SHORT_CYC = TRYWAIT_SHORT_MS * CLK_KHZ;
    localparam int QDEB_0_CYC = QDEB_0_MS * CLK_KHZ;
    localparam int QDEB_1_CYC = QDEB_1_MS * CLK_KHZ;
    localparam int QDEB_2_CYC = QDEB_2_MS * CLK_KHZ;
    localparam int QDEB_3_CYC = QDEB_3_MS * CLK_KHZ;

    typedef struct packed {
        logic fsm_run;
        logic vconn_on;
        logic try_sink_permit;
        logic dbg_acc_source_detect_en;
        logic dbg_acc_sink_detect_en;
        logic audio_acc_detect_en;
        logic source_role_detect_en;
        logic sink_role_detect_en;
        logic error_recovery_hold;
        logic vbus_ignore_on_attach;
        logic sink_exit_select;
        logic resistor_ladder_off;
        logic drp_toggle;
        logic [6:0] dual_role_duty_pct;
        logic [8:0] unattached_src_ua;
        logic forced_active;
        logic forced_no_source;
        logic [8:0] forced_ua;
        logic [1:0] adv_current_applied;
        logic [31:0] trywait_debounce_cyc;
        logic [31:0] quick_debounce_two_cyc;
    } tcc_cfg_t;

endpackage

// *** tb/tcc_cc_control_regs_tb.sv ***
// Self-checking bench for the CC control register bank
`timescale 1ns/1ps
module tcc_cc_control_regs_tb;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic want_dfp = 1'b0;
    logic want_vconn = 1'b0;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    logic [2:0] attach_state_code;
    logic fsm_vconn_request;
    tcc_pkg::tcc_cfg_t cfg;
    int n_errors = 0;
    int checked = 0;
    int i;
    logic [7:0] rst_v [7] = '{8'h00, 8'h8D, 8'h00, 8'h01, 8'h00, 8'h03, 8'h00};
    logic [7:0] mask_v [7] = '{8'h20, 8'hDF, 8'h7F, 8'h31, 8'h33, 8'h03, 8'h43};
    logic [8:0] ua_v [8] = '{9'h0, 9'h001, 9'h005, 9'h050, 9'h0B4, 9'h14A, 9'h0, 9'h0};
    logic [8:0] lp_v [4] = '{9'h050, 9'h005, 9'h001, 9'h050};
    logic [31:0] qd_v [4] = '{32'h1, 32'h2, 32'h3, 32'h14};

    always #2 clk = ~clk;

    tcc_cc_control_regs #(.TRYWAIT_SHORT_CYC(15), .QDEB_0_CYC(1),
        .QDEB_1_CYC(2), .QDEB_2_CYC(3), .QDEB_3_CYC(20)) uut (.clk(clk), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .attach_state_code(attach_state_code),
        .fsm_vconn_request(fsm_vconn_request), .cfg(cfg));
    tcc_fsm_model far_i (.clk(clk), .arst_n(arst_n), .want_dfp(want_dfp),
        .want_vconn(want_vconn), .attach_state_code(attach_state_code),
        .fsm_vconn_request(fsm_vconn_request));

    // ----------
    // Tasks
    // ----------
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        checked++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask
    // Extra edge at the end so cfg has settled on return
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        @(negedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        chk("rvalid", 32'h1, {31'h0, reg_rvalid});
        chk("rdata", {24'h0, exp}, {24'h0, reg_rdata});
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ----------
    // Sequence
    // ----------
    initial begin
        repeat (8) @(posedge clk);
        @(negedge clk);
        arst_n = 1'b1;
        for (i = 0; i < 7; i++) rd(8'h20 + 8'(i), rst_v[i]);
        chk("reset cfg", {32'h050, 32'(tcc_pkg::TRYWAIT_LONG_CYC)},
            {23'h0, cfg.unattached_src_ua, cfg.trywait_debounce_cyc});
        wr(8'h27, 8'hFF);
        rd(8'h27, 8'h00);
        $display("test reset done");
        for (i = 1; i < 7; i++) begin
            wr(8'h20 + 8'(i), 8'hFF);
            rd(8'h20 + 8'(i), mask_v[i]);
        end
        chk("flags", 32'hFFF, {20'h0, cfg.fsm_run, cfg.try_sink_permit,
            cfg.dbg_acc_source_detect_en, cfg.dbg_acc_sink_detect_en, cfg.audio_acc_detect_en,
            cfg.source_role_detect_en, cfg.sink_role_detect_en, cfg.error_recovery_hold,
            cfg.vbus_ignore_on_attach, cfg.sink_exit_select, cfg.resistor_ladder_off,
            cfg.drp_toggle});
        for (i = 1; i < 7; i++) wr(8'h20 + 8'(i), 8'h00);
        chk("flags off", 32'h0, {20'h0, cfg.fsm_run, cfg.vbus_ignore_on_attach,
            cfg.sink_exit_select, cfg.resistor_ladder_off, cfg.drp_toggle, cfg.forced_active});
        for (i = 0; i < 8; i++) begin
            wr(8'h21, 8'h01 << i);
            rd(8'h21, (8'h01 << i) & 8'hDF);
            chk("modes", {26'h0, 8'h01 << i} & 32'h1F | ({26'h0, 8'h01 << i} & 32'h40) >> 1,
                {26'h0, cfg.try_sink_permit, cfg.dbg_acc_source_detect_en,
                cfg.dbg_acc_sink_detect_en, cfg.audio_acc_detect_en,
                cfg.source_role_detect_en, cfg.sink_role_detect_en});
        end
        $display("test masks done");
        wr(8'h21, 8'h03);
        for (i = 0; i < 4; i++) begin
            wr(8'h22, 8'(i << 3));
            chk("lowpower ua", {23'h0, lp_v[i]}, {23'h0, cfg.unattached_src_ua});
            wr(8'h24, 8'(((i & 1) << 5) | i));
            chk("duty", 32'(35 + 5 * i), {25'h0, cfg.dual_role_duty_pct});
            chk("trywait", (i & 1) ? 32'hF : 32'(tcc_pkg::TRYWAIT_LONG_CYC),
                cfg.trywait_debounce_cyc);
            wr(8'h26, 8'(i));
            chk("quick deb", qd_v[i], cfg.quick_debounce_two_cyc);
        end
        for (i = 0; i < 8; i++) begin
            wr(8'h22, 8'(i));
            chk("forced", {21'h0, i != 0, i > 5, 1'b0, ua_v[i]},
                {21'h0, cfg.forced_active, cfg.forced_no_source, 1'b0, cfg.forced_ua});
        end
        $display("test codes done");
        want_vconn = 1'b1;
        wr(8'h21, 8'h80);
        chk("vconn auto", 32'h1, {31'h0, cfg.vconn_on});
        wr(8'h21, 8'h00);
        chk("vconn forced off", 32'h0, {31'h0, cfg.vconn_on});
        $display("test vconn done");
        wr(8'h22, 8'h20);
        wr(8'h20, 8'h20);
        wr(8'h22, 8'h40);
        rd(8'h20, 8'h20);
        chk("held", 32'h0, {30'h0, cfg.adv_current_applied});
        want_dfp = 1'b1;
        for (i = 0; i < 50 && cfg.adv_current_applied !== 2'h1; i++) @(negedge clk);
        chk("applied", 32'h1, {30'h0, cfg.adv_current_applied});
        if (cfg.adv_current_applied !== 2'h1) end_sim();
        rd(8'h20, 8'h00);
        wr(8'h22, 8'h60);
        wr(8'h20, 8'h20);
        rd(8'h20, 8'h00);
        chk("reserved kept", 32'h1, {30'h0, cfg.adv_current_applied});
        $display("test change request done");
        arst_n = 1'b0;
        repeat (2) @(negedge clk);
        arst_n = 1'b1;
        rd(8'h21, 8'h8D);
        $display("test second reset done");
        end_sim();
    end
endmodule

// *** tb/tcc_fsm_model.sv ***
// Behavioural attach state machine facing the register bank
`timescale 1ns/1ps
module tcc_fsm_model #(
    parameter int SETTLE = 4
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic want_dfp,
    input wire logic want_vconn,
    output logic [2:0] attach_state_code,
    output logic fsm_vconn_request
);
    logic [3:0] cnt_reg;
    // Attach settles slowly, so a pending change must wait
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg <= 4'h0;
        end else if (!want_dfp) begin
            cnt_reg <= 4'h0;
        end else if (cnt_reg != 4'(SETTLE)) begin
            cnt_reg <= cnt_reg + 4'h1;
        end
    end
    assign attach_state_code = (cnt_reg == 4'(SETTLE)) ? 3'h2 : 3'h1;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fsm_vconn_request <= 1'b0;
        end else begin
            fsm_vconn_request <= want_vconn;
        end
    end
endmodule

// *** tb/tcc_regs_checker.sv ***
// Assertion checker for the CC control register bank
`timescale 1ns/1ps
module tcc_regs_checker #(
    parameter int TRYWAIT_LONG_CYC = 120,
    parameter int TRYWAIT_SHORT_CYC = 15,
    parameter int QDEB_0_CYC = 1,
    parameter int QDEB_1_CYC = 2,
    parameter int QDEB_2_CYC = 3,
    parameter int QDEB_3_CYC = 20
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic [2:0] attach_state_code,
    input wire logic fsm_vconn_request,
    input wire tcc_pkg::tcc_cfg_t cfg
);
    // ----------
    // Properties
    // ----------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // Register lands one edge after the write, cfg one more
    wire logic w21 = reg_wr && reg_addr == 8'h21;
    wire logic w22 = reg_wr && reg_addr == 8'h22;
    wire logic w24 = reg_wr && reg_addr == 8'h24;
    function automatic int f_qd(input logic [1:0] c);
        return c[1] ? (c[0] ? QDEB_3_CYC : QDEB_2_CYC) : (c[0] ? QDEB_1_CYC : QDEB_0_CYC);
    endfunction
    a_vconn_gate: assert property (cfg.vconn_on |-> $past(fsm_vconn_request))
        else $error("vconn on without a request");
    a_mode_bits: assert property (w21 |-> ##2 ($past(reg_wdata[7], 2) || !cfg.vconn_on)
        && {cfg.try_sink_permit, cfg.dbg_acc_source_detect_en, cfg.dbg_acc_sink_detect_en,
        cfg.audio_acc_detect_en, cfg.source_role_detect_en, cfg.sink_role_detect_en}
        == {$past(reg_wdata[6], 2), $past(reg_wdata[4:0], 2)})
        else $error("mode enables not decoded");
    a_fsm_run: assert property (reg_wr && reg_addr == 8'h23 |-> ##2
        cfg.fsm_run == $past(reg_wdata[0], 2)) else $error("fsm run wrong");
    a_lock_trywait: assert property (w24 |-> ##2
        cfg.error_recovery_hold == $past(reg_wdata[4], 2) && cfg.trywait_debounce_cyc
        == ($past(reg_wdata[5], 2) ? TRYWAIT_SHORT_CYC : TRYWAIT_LONG_CYC))
        else $error("lock or trywait wrong");
    a_drp_duty: assert property (w24 ##2 cfg.drp_toggle |->
        cfg.dual_role_duty_pct == 7'(35 + 5 * $past(reg_wdata[1:0], 2)))
        else $error("duty wrong");
    a_drp_gate: assert property (cfg.drp_toggle == (cfg.source_role_detect_en
        && cfg.sink_role_detect_en) && (cfg.drp_toggle || cfg.dual_role_duty_pct == 7'h00))
        else $error("toggle gating wrong");
    a_sink_cond: assert property (reg_wr && reg_addr == 8'h25 |-> ##2
        {cfg.vbus_ignore_on_attach, cfg.sink_exit_select} == $past(reg_wdata[1:0], 2))
        else $error("sink conditions wrong");
    a_ladder_qdeb: assert property (reg_wr && reg_addr == 8'h26 |-> ##2
        cfg.resistor_ladder_off == $past(reg_wdata[6], 2)
        && cfg.quick_debounce_two_cyc == f_qd($past(reg_wdata[1:0], 2)))
        else $error("ladder or debounce wrong");
    a_lowpower_src: assert property (w22 |-> ##2 cfg.unattached_src_ua ==
        ($past(reg_wdata[4:3], 2) == 2'h1 ? 9'h005 : $past(reg_wdata[4:3], 2) == 2'h2
        ? 9'h001 : 9'h050)) else $error("low-power source wrong");
    a_forced_code: assert property (w22 |-> ##2
        cfg.forced_active == ($past(reg_wdata[2:0], 2) != 3'h0)
        && cfg.forced_no_source == ($past(reg_wdata[2:0], 2) > 3'h5))
        else $error("forced code wrong");
    a_apply_dfp: assert property ($changed(cfg.adv_current_applied) |->
        $past(attach_state_code, 2) == 3'h2 && cfg.adv_current_applied != 2'h3)
        else $error("current applied outside DFP");
    c_drp: cover property (w21 ##2 cfg.drp_toggle);
    c_apply: cover property ($changed(cfg.adv_current_applied));
    c_nosrc: cover property (w22 ##2 cfg.forced_no_source);
endmodule

bind tcc_cc_control_regs tcc_regs_checker #(
    .TRYWAIT_LONG_CYC(TRYWAIT_LONG_CYC), .TRYWAIT_SHORT_CYC(TRYWAIT_SHORT_CYC),
    .QDEB_0_CYC(QDEB_0_CYC), .QDEB_1_CYC(QDEB_1_CYC),
    .QDEB_2_CYC(QDEB_2_CYC), .QDEB_3_CYC(QDEB_3_CYC)
) chk_i (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .attach_state_code(attach_state_code), .fsm_vconn_request(fsm_vconn_request),
    .cfg(cfg));
